/* hdl/line_maint_ctrl.sv */
// Line maintenance control: registers, pattern insertion, alarms and loopbacks
`timescale 1ns/1ps
module line_maint_ctrl
  import line_maint_pkg::*;
(
  input wire logic i_mclk, // Master clock, 200 MHz
  input wire logic i_nrst, // Synchronous reset, active low
  input wire logic i_wr, // Host write strobe, pin, active high
  input wire logic i_rd, // Host read strobe, pin, active high
  input wire logic [7:0] i_addr, // Host register address, pin
  input wire logic [7:0] i_wdata, // Host write data, pin
  input wire logic i_transmit_clock, // Transmit clock pin
  input wire logic i_tx_data, // Transmit data pin
  input wire logic i_rdp, // Receive data positive from receiver
  input wire logic i_rdn, // Receive data negative from receiver
  input wire logic i_rx_clk, // Recovered receive clock level
  input wire logic i_rx_bit_en, // One receive bit valid this cycle
  input wire logic i_los, // Loss of signal present
  input wire logic i_e1_mode, // E1 mode when high, T1/J1 when low
  output logic [7:0] o_rdata, // Host read data
  output logic o_rdata_en, // Drive host data bus
  output logic o_line_out_tip, // Line mark, positive
  output logic o_line_out_ring, // Line mark, negative
  output logic o_receive_data_positive, // Receive data positive out
  output logic o_receive_data_negative, // Receive data negative out
  output logic o_rx_clk, // Receive clock out
  output logic o_analog_loop, // Analog loopback enable
  output logic o_alarm_criterion, // LOS/AIS criterion select
  output logic o_auto_loop_active, // Automatic remote loop engaged
  output logic o_prbs_error // Received sequence bit mismatch
);
  localparam int SW = 20;
  logic [SW-1:0] s1_q, s2_q;
  logic [2:0] prev_q;
  logic transmit_clock_s, txd_s, wr_s, rd_s, wr_p, rd_p, transmit_clock_p, tick;
  logic [7:0] addr_s, wd_s;
  logic [7:0] pac_q, pac_d, lec_q, lec_d, len_q, len_d, txc_q, txc_d;
  logic [7:0] rac_q, rac_d, rdc_q, rdc_d, rdata_q, rdata_d, sts;
  logic rden_q, rden_d;
  pat_e pat;
  logic clksel, inv, alarm_insert_enable, auto_all_ones, auto_remote_loop_enable, remote_loop_enable, digital_loop_enable, rem, bit_c;
  logic line_q, line_d, pol_q, pol_d, tip_q, tip_d, ring_q, ring_d;
  logic rxp_q, rxp_d, rxn_q, rxn_d, rck_q, rck_d;
  logic [19:0] hist_q, hist_d;
  logic perr_q, perr_d, aloop_q, aloop_d, act_m, deact_m;
  loop_e loop_q, loop_d;
  pat_if p ();

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; edges are taken from the second stage only
  always_ff @(posedge i_mclk)
  begin
    if (!i_nrst)
    begin
      s1_q <= '0;
      s2_q <= '0;
      prev_q <= '0;
    end
    else
    begin
      s1_q <= {i_transmit_clock, i_tx_data, i_wr, i_rd, i_addr, i_wdata};
      s2_q <= s1_q;
      prev_q <= {transmit_clock_s, wr_s, rd_s};
    end
  end

  assign {transmit_clock_s, txd_s, wr_s, rd_s, addr_s, wd_s} = s2_q;
  assign wr_p = wr_s & ~prev_q[1];
  assign rd_p = rd_s & ~prev_q[0];
  assign transmit_clock_p = transmit_clock_s & ~prev_q[2];

  ////////////////////////////////////////////////////////////////////////////
  // Control fields
  assign pat = pat_e'(pac_q[PATT_LSB +: 2]);
  assign clksel = pac_q[CLKSEL_BIT];
  assign inv = pac_q[INV_BIT];
  assign alarm_insert_enable = pac_q[ALARM_INSERT_ENABLE_BIT];
  assign auto_all_ones = pac_q[AUTO_ALL_ONES_BIT];
  assign auto_remote_loop_enable = lec_q[AUTO_REMOTE_LOOP_ENABLE_BIT];
  assign remote_loop_enable = lec_q[RLP_BIT];
  assign digital_loop_enable = lec_q[DLP_BIT];
  assign sts = {6'h00, perr_q, aloop_q};
  // Pattern bit time: every master clock, or each transmit clock rising edge
  assign tick = clksel | transmit_clock_p;

  // Register file; strobes act once on their synchronised rising edge
  always_comb
  begin
    pac_d = pac_q;
    lec_d = lec_q;
    len_d = len_q;
    txc_d = txc_q;
    rac_d = rac_q;
    rdc_d = rdc_q;
    rdata_d = rdata_q;
    rden_d = rd_s;
    if (wr_p)
    begin
      if (addr_s == PAC_OFS)
        pac_d = wd_s & PAC_MASK;
      else if (addr_s == LEC_OFS)
        lec_d = wd_s & LEC_MASK;
      else if (addr_s == LEN_OFS)
        len_d = wd_s & LEN_MASK;
      else if (addr_s == TXC_OFS)
        txc_d = wd_s;
      else if (addr_s == RAC_OFS)
        rac_d = wd_s;
      else if (addr_s == RDC_OFS)
        rdc_d = wd_s;
    end
    if (rd_p)
    begin
      if (addr_s == PAC_OFS)
        rdata_d = pac_q;
      else if (addr_s == LEC_OFS)
        rdata_d = lec_q;
      else if (addr_s == LEN_OFS)
        rdata_d = len_q;
      else if (addr_s == TXC_OFS)
        rdata_d = txc_q;
      else if (addr_s == RAC_OFS)
        rdata_d = rac_q;
      else if (addr_s == RDC_OFS)
        rdata_d = rdc_q;
      else if (addr_s == STS_OFS)
        rdata_d = sts;
      else
        rdata_d = 8'h00;
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_nrst)
    begin
      pac_q <= PAC_RST;
      lec_q <= LEC_RST;
      len_q <= LEN_RST;
      txc_q <= TXC_RST;
      rac_q <= RAC_RST;
      rdc_q <= RDC_RST;
      rdata_q <= 8'h00;
      rden_q <= 1'b0;
    end
    else
    begin
      pac_q <= pac_d;
      lec_q <= lec_d;
      len_q <= len_d;
      txc_q <= txc_d;
      rac_q <= rac_d;
      rdc_q <= rdc_d;
      rdata_q <= rdata_d;
      rden_q <= rden_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Generator hookup; code restarts from its top bit whenever not selected
  assign p.tick = tick;
  assign p.e1 = i_e1_mode;
  assign p.inv = inv;
  assign p.restart = (pat != PAT_CODE);
  assign p.len_sel = len_q[TXLEN_LSB +: 2];
  assign p.code = txc_q;

  pat_gen u_gen (
    .i_mclk(i_mclk),
    .i_nrst(i_nrst),
    .p(p.gen)
  );

  // Transmit selection; loss-of-signal all ones wins over every loopback
  assign rem = remote_loop_enable | (loop_q == LOOP_ACT);
  always_comb
  begin
    case (pat)
      PAT_ZERO: bit_c = clksel ? 1'b0 : txd_s;
      PAT_ONES: bit_c = 1'b1;
      PAT_PRBS: bit_c = p.prbs_bit;
      PAT_CODE: bit_c = p.code_bit;
      default: bit_c = txd_s;
    endcase
    if (rem)
      bit_c = i_rdp;
    if (auto_all_ones && i_los && pat == PAT_ONES)
      bit_c = 1'b1;
    line_d = line_q;
    pol_d = pol_q;
    tip_d = tip_q;
    ring_d = ring_q;
    if (tick)
    begin
      line_d = bit_c;
      tip_d = bit_c & ~pol_q;
      ring_d = bit_c & pol_q;
      pol_d = pol_q ^ bit_c;
    end
  end

  // Receive outputs: digital loop feeds transmit data, alarm forces ones
  always_comb
  begin
    rxp_d = digital_loop_enable ? txd_s : i_rdp;
    rxn_d = digital_loop_enable ? 1'b0 : i_rdn;
    rck_d = digital_loop_enable ? transmit_clock_s : i_rx_clk;
    if (i_los && alarm_insert_enable)
    begin
      rxp_d = 1'b1;
      rxn_d = 1'b1;
      rck_d = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Doubled code image: two repetitions of the used low bits
  function automatic logic [15:0] dbl(input logic [7:0] c, input logic [1:0] ls);
    logic [15:0] v;
    v = 16'(c & (8'hff >> (2'd3 - ls)));
    dbl = v | (v << (4'd5 + 4'(ls)));
  endfunction

  // A code counts only after two whole repetitions to avoid chance matches
  assign act_m = (hist_q[15:0] & dbl(8'hff, len_q[RALEN_LSB +: 2])) == dbl(rac_q, len_q[RALEN_LSB +: 2]);
  assign deact_m = (hist_q[15:0] & dbl(8'hff, len_q[RDLEN_LSB +: 2])) == dbl(rdc_q, len_q[RDLEN_LSB +: 2]);

  // Receive history, sequence check and automatic loop state
  always_comb
  begin
    hist_d = i_rx_bit_en ? {hist_q[18:0], i_rdp} : hist_q;
    perr_d = i_rx_bit_en && pat == PAT_PRBS &&
             ((i_rdp ^ inv) != (i_e1_mode ? (hist_q[E1_TAP_A] ^ hist_q[E1_TAP_B])
                                           : (hist_q[T1_TAP_A] ^ hist_q[T1_TAP_B])));
    case (loop_q)
      LOOP_IDLE: loop_d = (auto_remote_loop_enable && act_m) ? LOOP_ACT : LOOP_IDLE;
      LOOP_ACT: loop_d = (!auto_remote_loop_enable || deact_m) ? LOOP_IDLE : LOOP_ACT;
      default: loop_d = LOOP_IDLE;
    endcase
    aloop_d = (loop_d == LOOP_ACT);
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_nrst)
    begin
      line_q <= 1'b0;
      pol_q <= 1'b0;
      tip_q <= 1'b0;
      ring_q <= 1'b0;
      rxp_q <= 1'b0;
      rxn_q <= 1'b0;
      rck_q <= 1'b0;
      hist_q <= '0;
      perr_q <= 1'b0;
      aloop_q <= 1'b0;
      loop_q <= LOOP_IDLE;
    end
    else
    begin
      line_q <= line_d;
      pol_q <= pol_d;
      tip_q <= tip_d;
      ring_q <= ring_d;
      rxp_q <= rxp_d;
      rxn_q <= rxn_d;
      rck_q <= rck_d;
      hist_q <= hist_d;
      perr_q <= perr_d;
      aloop_q <= aloop_d;
      loop_q <= loop_d;
    end
  end

  // Outputs straight from flip-flops
  assign o_rdata = rdata_q;
  assign o_rdata_en = rden_q;
  assign o_line_out_tip = tip_q;
  assign o_line_out_ring = ring_q;
  assign o_receive_data_positive = rxp_q;
  assign o_receive_data_negative = rxn_q;
  assign o_rx_clk = rck_q;
  assign o_analog_loop = lec_q[ALP_BIT];
  assign o_alarm_criterion = pac_q[CRIT_BIT];
  assign o_auto_loop_active = aloop_q;
  assign o_prbs_error = perr_q;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);

  sequence plain_s;
    tick && !rem && !(auto_all_ones && i_los && pat == PAT_ONES);
  endsequence
  norm_zero_a: assert property (plain_s and pat == PAT_ZERO |=> line_q == ($past(clksel) ? 1'b0 : $past(txd_s)))
    else $error("pattern 00 line bit wrong");
  ones_a: assert property (tick && pat == PAT_ONES && !rem |=> line_q && (tip_q ^ ring_q))
    else $error("all ones not transmitted");
  prbs_a: assert property (plain_s and pat == PAT_PRBS |=> line_q == $past(p.prbs_bit))
    else $error("sequence bit not transmitted");
  code_a: assert property (plain_s and pat == PAT_CODE |=> line_q == $past(txc_q[u_gen.idx_q]))
    else $error("inband code bit not transmitted");
  clk_sel_a: assert property (!clksel && tick |=> !tick)
    else $error("transmit clock timing gave back-to-back bits");
  inv_a: assert property (plain_s and pat == PAT_PRBS && $stable(inv) |=> line_q == ($past(u_gen.fb) ^ $past(inv)))
    else $error("sequence inversion wrong");
  crit_a: assert property (wr_p && addr_s == PAC_OFS |=> o_alarm_criterion == $past(wd_s[CRIT_BIT]))
    else $error("criterion select not applied");
  ais_a: assert property (i_los && alarm_insert_enable |=> rxp_q && rxn_q && rck_q)
    else $error("alarm ones not inserted");
  no_ais_a: assert property (!alarm_insert_enable && !digital_loop_enable |=> rxp_q == $past(i_rdp))
    else $error("receive data altered without alarm");
  auto_all_ones_a: assert property (tick && auto_all_ones && i_los && pat == PAT_ONES |=> line_q)
    else $error("auto all ones missing");
  auto_remote_loop_enable_a: assert property (!auto_remote_loop_enable |=> loop_q == LOOP_IDLE && !rem || remote_loop_enable)
    else $error("auto loop active while disabled");
  act_a: assert property (loop_q == LOOP_IDLE && auto_remote_loop_enable && act_m |=>
                          aloop_q ##1 (aloop_q || !$past(auto_remote_loop_enable) || $past(deact_m)))
    else $error("activate code ignored");
  rlp_a: assert property (tick && remote_loop_enable && !(auto_all_ones && i_los && pat == PAT_ONES) |=> line_q == $past(i_rdp))
    else $error("remote loop data wrong");
  alp_a: assert property (wr_p && addr_s == LEC_OFS |=> o_analog_loop == $past(wd_s[ALP_BIT]))
    else $error("analog loop not applied");
  dlp_a: assert property (digital_loop_enable && !(i_los && alarm_insert_enable) |=> rxp_q == $past(txd_s) && !rxn_q)
    else $error("digital loop data wrong");
  rst_a: assert property ($rose(i_nrst) |-> len_q == LEN_RST && txc_q == TXC_RST && rac_q == RAC_RST)
    else $error("code registers not at reset value");
  rst2_a: assert property ($rose(i_nrst) |-> rdc_q == RDC_RST && len_q[RDLEN_LSB +: 2] == 2'b01)
    else $error("deactivate code not at reset value");
  hold_a: assert property (!wr_p |=> $stable(txc_q) && $stable(len_q))
    else $error("code register changed without a write");

  code_c: cover property (tick && pat == PAT_CODE ##1 tick && pat == PAT_CODE);
  loop_c: cover property (loop_q == LOOP_IDLE ##1 loop_q == LOOP_ACT);
  ais_c: cover property (i_los && alarm_insert_enable);
  perr_c: cover property (perr_q);
endmodule

/* hdl/line_maint_pkg.sv */
// Constants, field positions and types for the line maintenance control block
package line_maint_pkg;
  // Register offsets on the host control port
  localparam logic [7:0] PAC_OFS = 8'h0d;
  localparam logic [7:0] LEC_OFS = 8'h0e;
  localparam logic [7:0] LEN_OFS = 8'hf0;
  localparam logic [7:0] TXC_OFS = 8'h10;
  localparam logic [7:0] RAC_OFS = 8'h11;
  localparam logic [7:0] RDC_OFS = 8'h12;
  localparam logic [7:0] STS_OFS = 8'h30;
  // Values after reset
  localparam logic [7:0] PAC_RST = 8'h00;
  localparam logic [7:0] LEC_RST = 8'h00;
  localparam logic [7:0] LEN_RST = 8'h01;
  localparam logic [7:0] TXC_RST = 8'h01;
  localparam logic [7:0] RAC_RST = 8'h01;
  localparam logic [7:0] RDC_RST = 8'h09;
  // Writable bits; reserved bits read zero
  localparam logic [7:0] PAC_MASK = 8'h7f;
  localparam logic [7:0] LEC_MASK = 8'h0f;
  localparam logic [7:0] LEN_MASK = 8'h3f;
  // Field positions
  localparam int PATT_LSB = 5;
  localparam int CLKSEL_BIT = 4;
  localparam int INV_BIT = 3;
  localparam int CRIT_BIT = 2;
  localparam int ALARM_INSERT_ENABLE_BIT = 1;
  localparam int AUTO_ALL_ONES_BIT = 0;
  localparam int AUTO_REMOTE_LOOP_ENABLE_BIT = 3;
  localparam int RLP_BIT = 2;
  localparam int ALP_BIT = 1;
  localparam int DLP_BIT = 0;
  localparam int TXLEN_LSB = 4;
  localparam int RALEN_LSB = 2;
  localparam int RDLEN_LSB = 0;
  // Sequence generator
  localparam int LFSR_W = 20;
  localparam int E1_TAP_A = 14;
  localparam int E1_TAP_B = 13;
  localparam int T1_TAP_A = 19;
  localparam int T1_TAP_B = 16;
  localparam logic [LFSR_W-1:0] LFSR_SEED = 20'h0_0001;
  localparam logic [3:0] CODE_MIN_LEN = 4'h5;
  typedef enum logic [1:0] {PAT_ZERO = 2'b00, PAT_ONES = 2'b01, PAT_PRBS = 2'b10, PAT_CODE = 2'b11} pat_e;
  typedef enum logic [1:0] {LOOP_IDLE = 2'b01, LOOP_ACT = 2'b10} loop_e;
endpackage

/* hdl/pat_if.sv */
// Interface between the control logic and the pattern generator
`timescale 1ns/1ps
interface pat_if;
  logic tick;
  logic e1;
  logic inv;
  logic restart;
  logic [1:0] len_sel;
  logic [7:0] code;
  logic prbs_bit;
  logic code_bit;
  modport gen (input tick, e1, inv, restart, len_sel, code, output prbs_bit, code_bit);
  modport ctl (output tick, e1, inv, restart, len_sel, code, input prbs_bit, code_bit);
endinterface

/* hdl/pat_gen.sv */
// Pseudo-random sequence and inband code generator
`timescale 1ns/1ps
module pat_gen
  import line_maint_pkg::*;
(
  input wire logic i_mclk, // Master clock
  input wire logic i_nrst, // Synchronous reset, active low
  pat_if.gen p // Pattern controls and bits
);
  logic [LFSR_W-1:0] lfsr_q, lfsr_d;
  logic [2:0] idx_q, idx_d;
  logic [2:0] last;
  logic fb;

  ////////////////////////////////////////////////////////////////////////////
  // Feedback by line mode; outputs are the current bits
  assign fb = p.e1 ? (lfsr_q[E1_TAP_A] ^ lfsr_q[E1_TAP_B]) : (lfsr_q[T1_TAP_A] ^ lfsr_q[T1_TAP_B]);
  assign last = 3'(CODE_MIN_LEN - 4'h1 + 4'(p.len_sel));
  assign p.prbs_bit = fb ^ p.inv;
  assign p.code_bit = p.code[idx_q];

  // Next state; all-zero lock-up is reseeded so the sequence never stalls
  always_comb
  begin
    lfsr_d = lfsr_q;
    idx_d = idx_q;
    if (p.tick)
    begin
      lfsr_d = {lfsr_q[LFSR_W-2:0], fb};
      if (lfsr_q == '0)
        lfsr_d = LFSR_SEED;
      idx_d = (idx_q == 3'h0) ? last : idx_q - 3'h1;
    end
    if (p.restart)
      idx_d = last;
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_nrst)
    begin
      lfsr_q <= LFSR_SEED;
      idx_q <= 3'h4;
    end
    else
    begin
      lfsr_q <= lfsr_d;
      idx_q <= idx_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);

  code_wrap_a: assert property (p.tick && !p.restart && idx_q == 3'h0 |=> idx_q == $past(last))
    else $error("inband code did not restart at its top bit");
  code_step_a: assert property (p.tick && !p.restart && idx_q != 3'h0 |=> idx_q == $past(idx_q) - 3'h1)
    else $error("inband code bit order broken");
  code_len_a: assert property (idx_q <= last || $changed(p.len_sel))
    else $error("inband code index beyond selected length");
  lfsr_live_a: assert property (p.tick ##1 p.tick |-> lfsr_q != '0)
    else $error("sequence register locked at zero");
  wrap_c: cover property (p.tick && !p.restart && idx_q == 3'h0);
endmodule

/* sim/line_maintenance_control_bench.sv */
// Self-checking bench for the line maintenance control block
`timescale 1ns/1ps
module line_maintenance_control_bench;
  import line_maint_pkg::*;
  logic i_mclk = 1'b0;
  logic i_nrst = 1'b0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [7:0] i_wdata = 8'h00;
  logic i_transmit_clock = 1'b0;
  logic i_tx_data = 1'b0;
  logic i_rdp = 1'b0;
  logic i_rdn = 1'b0;
  logic i_rx_clk = 1'b0;
  logic i_rx_bit_en = 1'b0;
  logic i_los = 1'b0;
  logic i_e1_mode = 1'b1;
  logic [7:0] o_rdata;
  logic o_rdata_en, o_line_out_tip, o_line_out_ring, o_receive_data_positive, o_receive_data_negative;
  logic o_rx_clk, o_analog_loop, o_alarm_criterion, o_auto_loop_active, o_prbs_error;
  logic [7:0] rv;
  logic [1:0] lv;
  logic bits [0:79];
  int miscompares = 0;
  int tests_run = 0;
  int n;
  wire mk = o_line_out_tip | o_line_out_ring;

  line_maint_ctrl DUT (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_wr(i_wr), .i_rd(i_rd), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_transmit_clock(i_transmit_clock), .i_tx_data(i_tx_data), .i_rdp(i_rdp),
    .i_rdn(i_rdn), .i_rx_clk(i_rx_clk), .i_rx_bit_en(i_rx_bit_en), .i_los(i_los), .i_e1_mode(i_e1_mode),
    .o_rdata(o_rdata), .o_rdata_en(o_rdata_en), .o_line_out_tip(o_line_out_tip),
    .o_line_out_ring(o_line_out_ring), .o_receive_data_positive(o_receive_data_positive),
    .o_receive_data_negative(o_receive_data_negative), .o_rx_clk(o_rx_clk), .o_analog_loop(o_analog_loop),
    .o_alarm_criterion(o_alarm_criterion), .o_auto_loop_active(o_auto_loop_active),
    .o_prbs_error(o_prbs_error));

  // 200 MHz master clock
  always #2.5 i_mclk = ~i_mclk;

  //////////////////////////////////////////////////////////////////////////////
  // Inputs always move 1 ns after the rising edge, clear of the sampling point
  task cyc(input int k);
    repeat (k) @(posedge i_mclk);
    #1;
  endtask

  task chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task wrap_up;
    $display("tests_run=%0d miscompares=%0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Strobe is held long enough for the two-flop synchroniser plus margin
  task wr(input logic [7:0] a, input logic [7:0] d);
    i_addr = a;
    i_wdata = d;
    cyc(3);
    i_wr = 1'b1;
    cyc(4);
    i_wr = 1'b0;
    cyc(3);
  endtask

  task rd(input logic [7:0] a, output logic [7:0] d);
    i_addr = a;
    cyc(3);
    i_rd = 1'b1;
    cyc(4);
    d = o_rdata;
    chk({7'h0, o_rdata_en}, 8'h01);
    i_rd = 1'b0;
    cyc(4);
  endtask

  task rchk(input logic [7:0] a, input logic [7:0] exp);
    rd(a, rv);
    chk(rv, exp);
  endtask

  // Several cycles of line marks against one expected level
  task marks(input logic exp);
    repeat (8)
    begin
      chk({7'h0, mk}, {7'h0, exp});
      cyc(1);
    end
  endtask

  task tpulse;
    i_transmit_clock = 1'b1;
    cyc(3);
    i_transmit_clock = 1'b0;
    cyc(5);
  endtask

  // Received bits, most significant first, one valid strobe each
  task send(input logic [7:0] code, input int len, input int reps);
    repeat (reps)
      for (int i = len - 1; i >= 0; i--)
      begin
        i_rdp = code[i];
        i_rx_bit_en = 1'b1;
        cyc(1);
        i_rx_bit_en = 1'b0;
        cyc(1);
      end
  endtask

  task wait_auto(input logic exp);
    n = 0;
    while (o_auto_loop_active !== exp && n < 20)
    begin
      cyc(1);
      n++;
    end
    chk({7'h0, o_auto_loop_active}, {7'h0, exp});
    if (n >= 20)
      wrap_up();
  endtask

  // Repeating code on transmit clock edges: MSB on the first edge, restart at once
  task code_run(input logic [7:0] len, input logic [7:0] code, input int l);
    wr(PAC_OFS, 8'h10);
    wr(LEN_OFS, len);
    wr(TXC_OFS, code);
    wr(PAC_OFS, 8'h60);
    for (int i = 0; i < 3 * l; i++)
    begin
      tpulse();
      chk({7'h0, mk}, {7'h0, code[l - 1 - (i % l)]});
    end
  endtask

  // Captured sequence must obey its recurrence, inverted when asked
  task prbs_run(input logic e1, input logic inv, input int ta, input int tb);
    i_e1_mode = e1;
    wr(PAC_OFS, 8'h10);
    wr(PAC_OFS, 8'h50 | {4'h0, inv, 3'h0});
    cyc(30);
    n = 0;
    for (int i = 0; i < 80; i++)
    begin
      bits[i] = mk;
      n += int'(mk);
      cyc(1);
    end
    chk({7'h0, n > 0}, 8'h01);
    for (int i = ta; i < 80; i++)
      chk({7'h0, bits[i]}, {7'h0, bits[i - ta] ^ bits[i - tb] ^ inv});
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    cyc(10);
    i_nrst = 1'b1;
    cyc(2);
    rchk(PAC_OFS, 8'h00);
    rchk(LEC_OFS, 8'h00);
    rchk(LEN_OFS, 8'h01);
    rchk(TXC_OFS, 8'h01);
    rchk(RAC_OFS, 8'h01);
    rchk(RDC_OFS, 8'h09);
    rchk(STS_OFS, 8'h00);
    rchk(8'h55, 8'h00);
    // Reserved bits drop, unmapped writes leave everything alone
    wr(8'h55, 8'hff);
    wr(PAC_OFS, 8'hff);
    rchk(PAC_OFS, 8'h7f);
    wr(LEC_OFS, 8'hff);
    rchk(LEC_OFS, 8'h0f);
    wr(LEN_OFS, 8'hff);
    rchk(LEN_OFS, 8'h3f);
    rchk(8'h55, 8'h00);
    wr(LEC_OFS, 8'h02);
    chk({7'h0, o_analog_loop}, 8'h01);
    wr(LEC_OFS, 8'h00);
    chk({7'h0, o_analog_loop}, 8'h00);
    wr(PAC_OFS, 8'h04);
    chk({7'h0, o_alarm_criterion}, 8'h01);
    wr(PAC_OFS, 8'h00);
    chk({7'h0, o_alarm_criterion}, 8'h00);
    // Normal data follows the transmit clock pin
    i_tx_data = 1'b1;
    cyc(4);
    tpulse();
    chk({7'h0, mk}, 8'h01);
    i_tx_data = 1'b0;
    cyc(4);
    tpulse();
    chk({7'h0, mk}, 8'h00);
    // All ones on the transmit clock: nothing moves without its edges
    wr(PAC_OFS, 8'h20);
    tpulse();
    lv = {o_line_out_tip, o_line_out_ring};
    cyc(20);
    chk({6'h0, o_line_out_tip, o_line_out_ring}, {6'h0, lv});
    tpulse();
    chk({6'h0, o_line_out_tip, o_line_out_ring}, {6'h0, ~lv});
    wr(PAC_OFS, 8'h30);
    marks(1'b1);
    // Remote loop carries the silent receive line instead of the ones
    wr(LEC_OFS, 8'h04);
    cyc(4);
    marks(1'b0);
    i_los = 1'b1;
    wr(PAC_OFS, 8'h31);
    cyc(4);
    marks(1'b1);
    wr(LEC_OFS, 8'h00);
    wr(PAC_OFS, 8'h11);
    cyc(4);
    marks(1'b0);
    // Alarm insertion on the receive outputs during loss of signal
    wr(PAC_OFS, 8'h02);
    chk({5'h0, o_receive_data_positive, o_receive_data_negative, o_rx_clk}, 8'h07);
    wr(PAC_OFS, 8'h00);
    chk({5'h0, o_receive_data_positive, o_receive_data_negative, o_rx_clk}, 8'h00);
    i_los = 1'b0;
    i_tx_data = 1'b1;
    wr(LEC_OFS, 8'h01);
    chk({6'h0, o_receive_data_positive, o_receive_data_negative}, 8'h02);
    i_tx_data = 1'b0;
    cyc(4);
    chk({6'h0, o_receive_data_positive, o_receive_data_negative}, 8'h00);
    wr(LEC_OFS, 8'h00);
    // Inband code insertion at two lengths
    code_run(LEN_RST, 8'h13, 5);
    code_run(8'h30, 8'ha5, 8);
    // Sequences in both line modes, plain, and inverted in E1 mode only
    prbs_run(1'b1, 1'b0, 15, 14);
    prbs_run(1'b1, 1'b1, 15, 14);
    prbs_run(1'b0, 1'b0, 20, 17);
    // Detector: captured sequence passes, one flipped bit trips its slot and one tap later
    i_rx_bit_en = 1'b1;
    for (int i = 0; i < 80; i++)
    begin
      i_rdp = bits[i] ^ (i == 60);
      cyc(1);
      if (i >= 20)
        chk({7'h0, o_prbs_error}, {7'h0, i == 60 || i == 77});
    end
    i_rx_bit_en = 1'b0;
    i_rdp = 1'b0;
    wr(PAC_OFS, 8'h00);
    // Automatic loop engaged by the default codes and released again
    wr(LEN_OFS, LEN_RST);
    wr(LEC_OFS, 8'h08);
    send(8'h01, 5, 2);
    wait_auto(1'b1);
    rchk(STS_OFS, 8'h01);
    send(8'h09, 6, 2);
    wait_auto(1'b0);
    wr(LEC_OFS, 8'h00);
    wrap_up();
  end
endmodule
